// [hdl/perf_monitor_regs.sv]
// performance monitor counters and latches of the
// e1 receive framer, read over the host port.
// assumes framer events are on mclk_i; host pins
// are asynchronous and are synchronised here.
`default_nettype none

module perf_monitor_regs #(
    parameter int RAI_MIN_CYC = perf_mon_pkg::RAI_MIN_CYC,
    parameter int RAI_MAX_CYC = perf_mon_pkg::RAI_MAX_CYC,
    parameter int JF_DEPTH = 32,
    parameter int JF_LEVEL_W = 6
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire perf_mon_pkg::host_in_t host_i,
    input wire perf_mon_pkg::rx_events_t ev_i,
    input wire logic [JF_LEVEL_W-1:0] jfifo_level_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    output logic jitter_rd_slow_o,
    output logic jitter_rd_fast_o,
    output logic rai_persist_o
);
    localparam int TW = perf_mon_pkg::RAI_TMR_W;
    localparam int CW = perf_mon_pkg::CNT_W;
    localparam int EW = perf_mon_pkg::EBIT_W;
    localparam logic [TW-1:0] TMIN = TW'(RAI_MIN_CYC);
    localparam logic [TW-1:0] TMAX = TW'(RAI_MAX_CYC);
    localparam logic [JF_LEVEL_W-1:0] JF_LOW =
        JF_LEVEL_W'(perf_mon_pkg::JF_MARGIN);
    localparam logic [JF_LEVEL_W-1:0] JF_HIGH =
        JF_LEVEL_W'(JF_DEPTH - perf_mon_pkg::JF_MARGIN);

    // ------------------------------------------------
    // state
    // ------------------------------------------------
    typedef struct packed {
        logic [1:0] cs_n_s;
        logic [1:0] rd_n_s;
        logic [1:0] wr_n_s;
        logic [4:0] addr_s1;
        logic [4:0] addr_s2;
        logic [7:0] din_s1;
        logic [7:0] din_s2;
        logic rd_act;
        logic wr_act;
        logic [4:0] rd_addr;
        logic [7:0] rdata;
        logic doe;
        logic [7:0] ovf;
        logic [7:0] ivec;
        logic [TW-1:0] rai_tmr;
        logic persist;
        logic window;
        logic jf_slow;
        logic jf_fast;
        logic sync_lost_d;
    } mon_state_t;

    mon_state_t s_q;
    mon_state_t s_d;

    // ------------------------------------------------
    // host strobes
    // ------------------------------------------------
    logic rd_now;
    logic wr_now;
    logic rd_end;
    logic wr_start;
    logic wr_prbs;

    assign rd_now = !s_q.cs_n_s[1] && !s_q.rd_n_s[1];
    assign wr_now = !s_q.cs_n_s[1] && !s_q.wr_n_s[1];
    assign rd_end = !rd_now && s_q.rd_act;
    assign wr_start = wr_now && !s_q.wr_act;
    assign wr_prbs = wr_start &&
        (s_q.addr_s2 == perf_mon_pkg::OFS_PRBS_ERR);

    // ------------------------------------------------
    // counters
    // ------------------------------------------------
    logic [CW-1:0] cnt8 [perf_mon_pkg::N_CNT8];
    logic [perf_mon_pkg::N_CNT8-1:0] wrap8;
    logic [perf_mon_pkg::N_CNT8-1:0] inc8;
    logic [perf_mon_pkg::N_CNT8-1:0] clr8;
    logic [perf_mon_pkg::N_CNT8-1:0] load8;
    logic [EW-1:0] ebit_cnt;
    logic ebit_wrap;

    logic jf_near_low;
    logic jf_near_high;
    logic jf_near;
    logic rai_cond;

    assign jf_near_low = jfifo_level_i <= JF_LOW;
    assign jf_near_high = jfifo_level_i >= JF_HIGH;
    assign jf_near = jf_near_low || jf_near_high;
    assign rai_cond = ev_i.rai_high && ev_i.ebits_low;

    always_comb begin
        inc8 = '0;
        clr8 = '0;
        load8 = '0;
        inc8[perf_mon_pkg::IDX_PRBS] = ev_i.prbs_err;
        load8[perf_mon_pkg::IDX_PRBS] = wr_prbs;
        inc8[perf_mon_pkg::IDX_SMF] = ev_i.crc_smf;
        clr8[perf_mon_pkg::IDX_SMF] = wr_prbs;
        // margin entries
        // each side counts its own entry, so a jump straight
        // from one margin into the other is not lost
        inc8[perf_mon_pkg::IDX_JFIFO] = (jf_near_low && !s_q.jf_slow) ||
            (jf_near_high && !s_q.jf_fast);
        inc8[perf_mon_pkg::IDX_SYNC] =
            ev_i.frame_tick && ev_i.sync_lost;
        clr8[perf_mon_pkg::IDX_SYNC] =
            ev_i.sync_lost && !s_q.sync_lost_d;
        inc8[perf_mon_pkg::IDX_FAS] = ev_i.fas_err;
    end

    // the written byte only matters for the prbs slot
    for (genvar i = 0; i < perf_mon_pkg::N_CNT8; i++) begin : g_cnt
        event_counter #(
            .W(CW)
        ) u_cnt (
            .mclk_i(mclk_i),
            .resetn_i(resetn_i),
            .inc_i(inc8[i]),
            .clr_i(clr8[i]),
            .load_i(load8[i]),
            .load_val_i(s_q.din_s2),
            .count_o(cnt8[i]),
            .wrap_o(wrap8[i])
        );
    end

    event_counter #(
        .W(EW)
    ) u_ebit (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .inc_i(ev_i.ebit_err),
        .clr_i(1'b0),
        .load_i(1'b0),
        .load_val_i({EW{1'b0}}),
        .count_o(ebit_cnt),
        .wrap_o(ebit_wrap)
    );

    // ------------------------------------------------
    // read mux
    // ------------------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        if (s_q.addr_s2 == perf_mon_pkg::OFS_PRBS_ERR) begin
            rd_mux = cnt8[perf_mon_pkg::IDX_PRBS];
        end else if (s_q.addr_s2 == perf_mon_pkg::OFS_PRBS_SMF) begin
            rd_mux = cnt8[perf_mon_pkg::IDX_SMF];
        end else if (s_q.addr_s2 == perf_mon_pkg::OFS_IVEC) begin
            rd_mux = s_q.ivec;
        end else if (s_q.addr_s2 == perf_mon_pkg::OFS_EBIT_HI) begin
            rd_mux = {6'h00, ebit_cnt[EW-1:CW]};
        end else if (s_q.addr_s2 == perf_mon_pkg::OFS_EBIT_LO) begin
            rd_mux = ebit_cnt[CW-1:0];
        end else if (s_q.addr_s2 == perf_mon_pkg::OFS_JFIFO) begin
            rd_mux = cnt8[perf_mon_pkg::IDX_JFIFO];
        end else if (s_q.addr_s2 == perf_mon_pkg::OFS_OVF) begin
            rd_mux = s_q.ovf;
        end else if (s_q.addr_s2 == perf_mon_pkg::OFS_SYNC_LOSS) begin
            rd_mux = cnt8[perf_mon_pkg::IDX_SYNC];
        end else if (s_q.addr_s2 == perf_mon_pkg::OFS_FAS_ERR) begin
            rd_mux = cnt8[perf_mon_pkg::IDX_FAS];
        end else if (s_q.addr_s2 == perf_mon_pkg::OFS_RAI_CRC) begin
            rd_mux = {6'h00, s_q.window, s_q.persist};
        end else begin
            rd_mux = perf_mon_pkg::RST_BYTE;
        end
    end

    // ------------------------------------------------
    // next state
    // ------------------------------------------------
    always_comb begin
        logic [7:0] ovf_set;
        ovf_set = 8'h00;
        s_d = s_q;
        s_d.cs_n_s = {s_q.cs_n_s[0], host_i.cs_n};
        s_d.rd_n_s = {s_q.rd_n_s[0], host_i.rd_n};
        s_d.wr_n_s = {s_q.wr_n_s[0], host_i.wr_n};
        s_d.addr_s1 = host_i.addr;
        s_d.addr_s2 = s_q.addr_s1;
        s_d.din_s1 = host_i.data;
        s_d.din_s2 = s_q.din_s1;
        s_d.rd_act = rd_now;
        s_d.wr_act = wr_now;
        s_d.sync_lost_d = ev_i.sync_lost;

        // snapshot at read start; clearing waits for the
        // strobe to end so the host sees the old value
        if (rd_now && !s_q.rd_act) begin
            s_d.rd_addr = s_q.addr_s2;
            s_d.rdata = rd_mux;
            s_d.doe = 1'b1;
        end
        if (rd_end) begin
            s_d.doe = 1'b0;
            if (s_q.rd_addr == perf_mon_pkg::OFS_OVF) begin
                s_d.ovf = s_q.ovf & ~s_q.rdata;
            end
            if (s_q.rd_addr == perf_mon_pkg::OFS_RAI_CRC &&
                s_q.rdata[perf_mon_pkg::RAI_WIN_BIT]) begin
                s_d.window = 1'b0;
            end
        end

        // sets are applied after clears so none is lost
        // prbs, e-bit, jitter, sync, fas, efas, bpv and crc overflow
        ovf_set[perf_mon_pkg::OVF_PRBS_BIT] =
            wrap8[perf_mon_pkg::IDX_PRBS];
        ovf_set[perf_mon_pkg::OVF_EBIT_BIT] = ebit_wrap;
        ovf_set[perf_mon_pkg::OVF_JFIFO_BIT] =
            wrap8[perf_mon_pkg::IDX_JFIFO];
        ovf_set[perf_mon_pkg::OVF_SYNC_BIT] =
            wrap8[perf_mon_pkg::IDX_SYNC];
        ovf_set[perf_mon_pkg::OVF_FAS_BIT] =
            wrap8[perf_mon_pkg::IDX_FAS];
        ovf_set[perf_mon_pkg::OVF_EFAS_BIT] = ev_i.efas_ovf;
        ovf_set[perf_mon_pkg::OVF_BPV_BIT] = ev_i.bpv_ovf;
        ovf_set[perf_mon_pkg::OVF_CRC_BIT] = ev_i.crc_ovf;
        s_d.ovf = s_d.ovf | ovf_set;

        if (ev_i.irq_raise) begin
            s_d.ivec = ev_i.irq_vector;
        end

        s_d.jf_slow = jf_near_low;
        s_d.jf_fast = jf_near_high;

        // timer saturates so a long run never re-enters
        // the window range
        if (rai_cond) begin
            if (s_q.rai_tmr < TMAX) begin
                s_d.rai_tmr = s_q.rai_tmr + {{(TW-1){1'b0}}, 1'b1};
            end
        end else begin
            s_d.rai_tmr = '0;
        end
        s_d.persist = rai_cond && (s_q.rai_tmr >= TMIN);
        if (!rai_cond && s_q.rai_tmr >= TMIN && s_q.rai_tmr < TMAX) begin
            s_d.window = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            s_q <= '0;
            s_q.cs_n_s <= 2'h3;
            s_q.rd_n_s <= 2'h3;
            s_q.wr_n_s <= 2'h3;
        end else begin
            s_q <= s_d;
        end
    end

    assign data_o = s_q.rdata;
    assign data_oe_o = s_q.doe;
    assign jitter_rd_slow_o = s_q.jf_slow;
    assign jitter_rd_fast_o = s_q.jf_fast;
    assign rai_persist_o = s_q.persist;

    // ------------------------------------------------
    // checks
    // ------------------------------------------------
    logic [7:0] ovf_src;
    assign ovf_src = {wrap8[0], ebit_wrap, wrap8[2], wrap8[3],
                      wrap8[4], ev_i.efas_ovf, ev_i.bpv_ovf, ev_i.crc_ovf};

    property p_prbs_inc;
        @(posedge mclk_i) disable iff (!resetn_i)
        ev_i.prbs_err && !wr_prbs && cnt8[0] != 8'hff
        |=> cnt8[0] == $past(cnt8[0]) + 8'h01;
    endproperty
    a_prbs_inc: assert property (p_prbs_inc) else $error("prbs count missed");

    property p_smf_inc;
        @(posedge mclk_i) disable iff (!resetn_i)
        ev_i.crc_smf && !wr_prbs && cnt8[1] != 8'hff
        |=> cnt8[1] == $past(cnt8[1]) + 8'h01;
    endproperty
    a_smf_inc: assert property (p_smf_inc) else $error("smf count missed");

    property p_smf_clr;
        @(posedge mclk_i) disable iff (!resetn_i)
        wr_prbs && !ev_i.crc_smf |=> cnt8[1] == 8'h00;
    endproperty
    a_smf_clr: assert property (p_smf_clr) else $error("smf not cleared");

    property p_ivec;
        @(posedge mclk_i) disable iff (!resetn_i)
        ev_i.irq_raise |=> s_q.ivec == $past(ev_i.irq_vector);
    endproperty
    a_ivec: assert property (p_ivec) else $error("vector not held");

    property p_ebit_wrap;
        @(posedge mclk_i) disable iff (!resetn_i)
        ev_i.ebit_err && ebit_cnt == 10'h3ff
        |=> ebit_cnt == 10'h000 ##1 s_q.ovf[6];
    endproperty
    a_ebit_wrap: assert property (p_ebit_wrap) else $error("e-bit wrap lost");

    property p_jf_inc;
        @(posedge mclk_i) disable iff (!resetn_i)
        $rose(jf_near) && cnt8[2] != 8'hff
        |=> cnt8[2] == $past(cnt8[2]) + 8'h01;
    endproperty
    a_jf_inc: assert property (p_jf_inc) else $error("jitter entry missed");

    property p_jf_clk;
        @(posedge mclk_i) disable iff (!resetn_i)
        jf_near_low && !jf_near_high |=> jitter_rd_slow_o && !jitter_rd_fast_o;
    endproperty
    a_jf_clk: assert property (p_jf_clk) else $error("read clock not slowed");

    property p_ovf_prbs;
        @(posedge mclk_i) disable iff (!resetn_i)
        wrap8[0] |=> s_q.ovf[7];
    endproperty
    a_ovf_prbs: assert property (p_ovf_prbs) else $error("prbs overflow lost");

    property p_ovf_efas;
        @(posedge mclk_i) disable iff (!resetn_i)
        ev_i.efas_ovf |=> s_q.ovf[2];
    endproperty
    a_ovf_efas: assert property (p_ovf_efas) else $error("efas overflow lost");

    property p_ovf_bpv;
        @(posedge mclk_i) disable iff (!resetn_i)
        ev_i.bpv_ovf |=> s_q.ovf[1];
    endproperty
    a_ovf_bpv: assert property (p_ovf_bpv) else $error("bpv overflow lost");

    property p_ovf_clr;
        @(posedge mclk_i) disable iff (!resetn_i)
        rd_end && s_q.rd_addr == perf_mon_pkg::OFS_OVF && ovf_src == 8'h00
        |=> (s_q.ovf & $past(s_q.rdata)) == 8'h00;
    endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("latch not cleared");

    property p_sync_clr;
        @(posedge mclk_i) disable iff (!resetn_i)
        ev_i.sync_lost && !s_q.sync_lost_d && !ev_i.frame_tick
        |=> cnt8[3] == 8'h00;
    endproperty
    a_sync_clr: assert property (p_sync_clr) else $error("sync count kept");

    property p_persist;
        @(posedge mclk_i) disable iff (!resetn_i)
        !rai_cond |=> !s_q.persist;
    endproperty
    a_persist: assert property (p_persist) else $error("persist without rai");

    property p_window;
        @(posedge mclk_i) disable iff (!resetn_i)
        $rose(s_q.window) |-> $past(s_q.rai_tmr) >= TMIN && $past(s_q.rai_tmr) < TMAX;
    endproperty
    a_window: assert property (p_window) else $error("window out of range");
endmodule : perf_monitor_regs

`default_nettype wire

// [hdl/perf_mon_pkg.sv]
// constants, field layout and carriers for the
// receive performance monitor register page.
// assumes one 100 MHz clock and a host parallel port.
`default_nettype none

package perf_mon_pkg;
    // ------------------------------------------------
    // register offsets
    // ------------------------------------------------
    localparam logic [4:0] OFS_PRBS_ERR = 5'h10;
    localparam logic [4:0] OFS_PRBS_SMF = 5'h11;
    localparam logic [4:0] OFS_IVEC = 5'h12;
    localparam logic [4:0] OFS_EBIT_HI = 5'h13;
    localparam logic [4:0] OFS_EBIT_LO = 5'h14;
    localparam logic [4:0] OFS_JFIFO = 5'h15;
    localparam logic [4:0] OFS_OVF = 5'h16;
    localparam logic [4:0] OFS_SYNC_LOSS = 5'h17;
    localparam logic [4:0] OFS_FAS_ERR = 5'h18;
    localparam logic [4:0] OFS_RAI_CRC = 5'h19;

    // ------------------------------------------------
    // field layout
    // ------------------------------------------------
    localparam int CNT_W = 8;
    localparam int EBIT_W = 10;
    localparam int OVF_PRBS_BIT = 7;
    localparam int OVF_EBIT_BIT = 6;
    localparam int OVF_JFIFO_BIT = 5;
    localparam int OVF_SYNC_BIT = 4;
    localparam int OVF_FAS_BIT = 3;
    localparam int OVF_EFAS_BIT = 2;
    localparam int OVF_BPV_BIT = 1;
    localparam int OVF_CRC_BIT = 0;
    localparam int RAI_WIN_BIT = 1;
    localparam int RAI_PER_BIT = 0;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // counter slots of the eight bit bank
    localparam int N_CNT8 = 5;
    localparam int IDX_PRBS = 0;
    localparam int IDX_SMF = 1;
    localparam int IDX_JFIFO = 2;
    localparam int IDX_SYNC = 3;
    localparam int IDX_FAS = 4;

    // ------------------------------------------------
    // timing
    // ------------------------------------------------
    localparam int CLK_KHZ = 100_000;
    localparam int RAI_MIN_MS = 10;
    localparam int RAI_MAX_MS = 450;
    localparam int RAI_MIN_CYC = RAI_MIN_MS * CLK_KHZ;
    localparam int RAI_MAX_CYC = RAI_MAX_MS * CLK_KHZ;
    localparam int RAI_TMR_W = 26;
    localparam int JF_MARGIN = 4;

    // ------------------------------------------------
    // carriers
    // ------------------------------------------------
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [4:0] addr;
        logic [7:0] data;
    } host_in_t;

    typedef struct packed {
        logic prbs_err;
        logic crc_smf;
        logic ebit_err;
        logic fas_err;
        logic frame_tick;
        logic sync_lost;
        logic rai_high;
        logic ebits_low;
        logic efas_ovf;
        logic bpv_ovf;
        logic crc_ovf;
        logic irq_raise;
        logic [7:0] irq_vector;
    } rx_events_t;
endpackage : perf_mon_pkg

`default_nettype wire

// [hdl/event_counter.sv]
// one wrapping event counter with load and clear.
// assumes inc, clr and load come from the same clock.
`default_nettype none

module event_counter #(
    parameter int W = 8
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic inc_i,
    input wire logic clr_i,
    input wire logic load_i,
    input wire logic [W-1:0] load_val_i,
    output logic [W-1:0] count_o,
    output logic wrap_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic wrap;
    } cnt_state_t;

    cnt_state_t s_q;
    cnt_state_t s_d;

    always_comb begin
        logic [W-1:0] base;
        base = clr_i ? {W{1'b0}} : s_q.cnt;
        s_d = s_q;
        s_d.wrap = 1'b0;
        if (load_i) begin
            s_d.cnt = load_val_i;
        end else if (inc_i) begin
            if (base == {W{1'b1}}) begin
                s_d.cnt = {W{1'b0}};
                s_d.wrap = 1'b1;
            end else begin
                s_d.cnt = base + {{(W-1){1'b0}}, 1'b1};
            end
        end else begin
            s_d.cnt = base;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign count_o = s_q.cnt;
    assign wrap_o = s_q.wrap;
endmodule : event_counter

`default_nettype wire

// [verification/host_port_model.sv]
// host processor model: drives the parallel port pins of the counter page.
// assumes the design answers a read by raising data_oe_i within a few cycles.
`default_nettype none

module host_port_model (
    input wire logic mclk_i,
    input wire logic [7:0] data_i,
    input wire logic data_oe_i,
    output perf_mon_pkg::host_in_t host_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------
    // pins and shared data line
    // ------------------------------------------------
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [4:0] addr;
    logic [7:0] drv;

    // the data line carries the design's byte while it drives, else ours
    assign host_o = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n, addr: addr,
                      data: data_oe_i ? data_i : drv};

    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 5'h00;
        drv = 8'h00;
    end

    // ------------------------------------------------
    // one access; read strobes held until the answer is seen (at most 12 cycles), write strobes for 5 cycles
    // ------------------------------------------------
    task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] wd,
                          output logic [7:0] rd, output logic ok);
        int i;
        ok = 1'b0;
        rd = 8'h00;
        @(negedge mclk_i);
        addr = a;
        drv = wd;
        cs_n = 1'b0;
        if (wr) begin
            wr_n = 1'b0;
            repeat (5) @(negedge mclk_i);
            ok = 1'b1;
        end else begin
            rd_n = 1'b0;
            for (i = 0; i < 12 && !ok; i++) begin
                @(negedge mclk_i);
                if (data_oe_i === 1'b1) begin
                    rd = data_i;
                    ok = 1'b1;
                end
            end
        end
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        // no pull on the line: a released byte must not look like the old one
        drv = ~drv;
        repeat (6) @(negedge mclk_i);
    endtask : access
endmodule : host_port_model

`default_nettype wire

// [verification/e1_perf_monitor_counters_test.sv]
// self-checking bench for the receive performance monitor register page.
// assumes short rai thresholds (20 and 60 cycles) set through parameters.
`default_nettype none

module e1_perf_monitor_counters_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------
    // signals and instances
    // ------------------------------------------------
    logic mclk_i;
    logic resetn_i;
    perf_mon_pkg::host_in_t host;
    perf_mon_pkg::rx_events_t ev;
    logic [5:0] jlvl;
    logic [7:0] data;
    logic oe;
    logic slow;
    logic fast;
    logic persist;
    int n_mismatch = 0;
    int checks_done = 0;
    typedef struct {perf_mon_pkg::rx_events_t ev; int n; logic [4:0] addr; logic [7:0] exp;} row_t;
    row_t rows[5];

    perf_monitor_regs #(.RAI_MIN_CYC(20), .RAI_MAX_CYC(60)) perf_monitor_regs_i (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .host_i(host), .ev_i(ev), .jfifo_level_i(jlvl),
        .data_o(data), .data_oe_o(oe), .jitter_rd_slow_o(slow), .jitter_rd_fast_o(fast),
        .rai_persist_o(persist));

    host_port_model host_port_model_i (.mclk_i(mclk_i), .data_i(data), .data_oe_i(oe), .host_o(host));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    // ------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report

    task automatic miss(input string m);
        n_mismatch++;
        $display("MISMATCH at %0t: %s", $time, m);
    endtask : miss

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
        checks_done++;
        if (got !== exp) miss($sformatf("%s got %h exp %h", m, got, exp));
    endtask : chk8

    task automatic chk1(input logic got, input logic exp, input string m);
        checks_done++;
        if (got !== exp) miss($sformatf("%s got %b exp %b", m, got, exp));
    endtask : chk1

    task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host_port_model_i.access(1'b0, a, 8'h00, d, ok);
        if (!ok) begin
            miss("read got no answer");
            final_report();
        end
        chk8(d, exp, $sformatf("reg %h", a));
    endtask : rdchk

    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        logic [7:0] d;
        logic ok;
        host_port_model_i.access(1'b1, a, v, d, ok);
    endtask : wr

    // back to back pulses, levels already high are kept
    task automatic pulse(input perf_mon_pkg::rx_events_t e, input int n);
        @(negedge mclk_i);
        ev = ev | e;
        repeat (n) @(negedge mclk_i);
        ev = ev & ~e;
    endtask : pulse

    task automatic rai_run(input int n, input logic exp_p, input logic [7:0] exp_reg);
        ev.rai_high = 1'b1;
        ev.ebits_low = 1'b1;
        repeat (n) @(negedge mclk_i);
        chk1(persist, exp_p, "persist in run");
        ev.rai_high = 1'b0;
        repeat (3) @(negedge mclk_i);
        chk1(persist, 1'b0, "persist after run");
        rdchk(5'h19, exp_reg);
    endtask : rai_run

    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        resetn_i = 1'b0;
        ev = '0;
        jlvl = 6'h10;
        rows[0] = '{'{prbs_err: 1'b1, default: '0}, 5, 5'h10, 8'h05};
        rows[1] = '{'{crc_smf: 1'b1, default: '0}, 3, 5'h11, 8'h03};
        rows[2] = '{'{ebit_err: 1'b1, default: '0}, 3, 5'h14, 8'h03};
        rows[3] = '{'{fas_err: 1'b1, default: '0}, 4, 5'h18, 8'h04};
        rows[4] = '{'{irq_raise: 1'b1, irq_vector: 8'h5a, default: '0}, 1, 5'h12, 8'h5a};
        repeat (8) @(negedge mclk_i);
        resetn_i = 1'b1;
        for (int a = 5'h10; a <= 5'h1a; a++) rdchk(5'(a), 8'h00);
        foreach (rows[i]) begin
            pulse(rows[i].ev, rows[i].n);
            rdchk(rows[i].addr, rows[i].exp);
        end
        pulse('{irq_raise: 1'b1, irq_vector: 8'ha5, default: '0}, 1);
        rdchk(5'h12, 8'ha5);
        wr(5'h10, 8'hff);
        rdchk(5'h10, 8'hff);
        rdchk(5'h11, 8'h00);
        pulse('{prbs_err: 1'b1, default: '0}, 1);
        rdchk(5'h10, 8'h00);
        // ten bit e-bit count across the byte boundary, then wrap
        pulse('{ebit_err: 1'b1, default: '0}, 253);
        rdchk(5'h13, 8'h01);
        rdchk(5'h14, 8'h00);
        pulse('{ebit_err: 1'b1, default: '0}, 768);
        rdchk(5'h13, 8'h00);
        pulse('{fas_err: 1'b1, default: '0}, 252);
        rdchk(5'h18, 8'h00);
        ev.sync_lost = 1'b1;
        pulse('{frame_tick: 1'b1, default: '0}, 3);
        rdchk(5'h17, 8'h03);
        ev.sync_lost = 1'b0;
        @(negedge mclk_i);
        ev.sync_lost = 1'b1;
        pulse('{frame_tick: 1'b1, default: '0}, 1);
        rdchk(5'h17, 8'h01);
        pulse('{frame_tick: 1'b1, default: '0}, 255);
        rdchk(5'h17, 8'h00);
        // margin edges: fill 4 and depth minus 4 are both inside
        jlvl = 6'h04;
        repeat (3) @(negedge mclk_i);
        chk1(slow, 1'b1, "slow at low margin");
        chk1(fast, 1'b0, "fast at low margin");
        jlvl = 6'h1c;
        repeat (3) @(negedge mclk_i);
        chk1(slow, 1'b0, "slow at high margin");
        chk1(fast, 1'b1, "fast at high margin");
        jlvl = 6'h10;
        repeat (3) @(negedge mclk_i);
        chk1(fast, 1'b0, "fast off margin");
        rdchk(5'h15, 8'h02);
        repeat (254) begin
            @(negedge mclk_i) jlvl = 6'h00;
            @(negedge mclk_i) jlvl = 6'h10;
        end
        rdchk(5'h15, 8'h00);
        pulse('{efas_ovf: 1'b1, bpv_ovf: 1'b1, crc_ovf: 1'b1, default: '0}, 1);
        rdchk(5'h16, 8'hff);
        rdchk(5'h16, 8'h00);
        rai_run(30, 1'b1, 8'h02);
        rdchk(5'h19, 8'h00);
        rai_run(80, 1'b1, 8'h00);
        rai_run(10, 1'b0, 8'h00);
        // second reset in mid-run clears the vector
        resetn_i = 1'b0;
        repeat (8) @(negedge mclk_i);
        resetn_i = 1'b1;
        chk1(oe, 1'b0, "bus idle after reset");
        rdchk(5'h12, 8'h00);
        final_report();
    end
endmodule : e1_perf_monitor_counters_test

`default_nettype wire
